// ### sfpc_regs.vh
// Summary of operation
// R01 - erase always clears one whole row of 32 words, 96 bytes
// R02 - low table read and write reach word bits 15:0, word or byte size
// R03 - high table read and write reach word bits 23:16, word or byte size
// R04 - table address is page register bits 7:0 joined to 16-bit effective address
// R05 - each panel holds 128 rows, 4K words of 24 bits
// R06 - software updates page register whenever a panel boundary is crossed
// R07 - each panel has 32 word latches, filled in ascending order
// R08 - latch group starts at an address aligned to 32 words
// R09 - table write only updates a latch, no stall
// R10 - each row programmed needs its own programming cycle
// R11 - address low captures effective address 15:0 of last table instruction
// R12 - address upper captures effective address 23:16 of last table instruction
// R13 - key register is write only; 0x55 then 0xaa unlocks one cycle; the code keeps it unlocked until the next register write
// R14 - both address registers are directly writable by software
// R15 - program or erase lasts nominally 2 ms with core stalled throughout
// R16 - control bit 15 starts the operation, cleared by hardware at end
// R17 - control register selects erase or program, memory type and start
// R18 - software sets row operation and write enable before starting
// R19 - start ignored unless key pair came just before; key then disarmed
// R20 - start ignored unless write enable already set
`ifndef SFPC_REGS_VH
`define SFPC_REGS_VH
`define SFPC_OFS_CTRL 3'h0
`define SFPC_OFS_ADR_LO 3'h1
`define SFPC_OFS_ADR_UP 3'h2
`define SFPC_OFS_KEY 3'h3
`define SFPC_OFS_PAGE 3'h4
`define SFPC_CTRL_WR 15
`define SFPC_CTRL_WRITE_ENABLE_BIT 14
`define SFPC_CTRL_ERR 13
`define SFPC_CTRL_ERASE 6
`define SFPC_CTRL_OP_HI 3
`define SFPC_CTRL_OP_LO 0
`define SFPC_OP_ROW 4'h1
`define SFPC_CTRL_RESET 16'h0000
`define SFPC_ADR_RESET 16'h0000
`define SFPC_KEY_FIRST 8'h55
`define SFPC_KEY_SECOND 8'haa
`define SFPC_ROW_WORDS 32
`define SFPC_ROWS_PER_PANEL 128
`define SFPC_OP_TIME_US 17'd2000
`define SFPC_CLK_MHZ 17'd40
`define SFPC_OP_CYCLES (`SFPC_OP_TIME_US * `SFPC_CLK_MHZ)
`endif

// ### sfpc_latch_mem.v
`timescale 1ns/1ps
module sfpc_latch_mem (
  clk,
  wr_en,
  wr_idx,
  wr_be,
  wr_data,
  rd_idx,
  rd_data
);
  input wire clk;
  input wire wr_en;
  input wire [4:0] wr_idx;
  input wire [2:0] wr_be;
  input wire [23:0] wr_data;
  input wire [4:0] rd_idx;
  output wire [23:0] rd_data;
  genvar b;
  // per byte lane memory with registered read, one driver per lane
  generate
    for (b = 0; b < 3; b = b + 1) begin : g_lane
      reg [7:0] mem [0:31];
      reg [7:0] rd_r;
      always @(posedge clk) begin
        if (wr_en && wr_be[b]) begin
          mem[wr_idx] <= wr_data[b*8+7:b*8];
        end
        rd_r <= mem[rd_idx];
      end
      assign rd_data[b*8+7:b*8] = rd_r;
    end
  endgenerate
endmodule

// ### sfpc_op_timer.v
`timescale 1ns/1ps
module sfpc_op_timer #(
  parameter [16:0] CYCLES = 17'd80000
) (
  clk,
  rst_n,
  start,
  done
);
  input wire clk;
  input wire rst_n;
  input wire start;
  output reg done;
  reg [16:0] cnt_r;
  reg run_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 17'h00000;
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= CYCLES - 17'd1;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == 17'h00000) begin
          run_r <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 17'd1;
        end
      end
    end
  end
endmodule

// ### sfpc_top.v
`timescale 1ns/1ps
`include "sfpc_regs.vh"
module sfpc_top #(
  parameter [16:0] OP_CYCLES = `SFPC_OP_CYCLES
) (
  clk,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  tbl_valid,
  tbl_write,
  tbl_high,
  tbl_byte,
  tbl_ea,
  tbl_wdata,
  tbl_rdata,
  tbl_rvalid,
  cpu_stall,
  arr_addr,
  arr_rd,
  arr_rdata,
  arr_erase,
  arr_wr,
  arr_wdata
);
  input wire clk;
  input wire rst_n;
  input wire [2:0] reg_addr;
  input wire [15:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [15:0] reg_rdata;
  input wire tbl_valid;
  input wire tbl_write;
  input wire tbl_high;
  input wire tbl_byte;
  input wire [15:0] tbl_ea;
  input wire [15:0] tbl_wdata;
  output reg [15:0] tbl_rdata;
  output reg tbl_rvalid;
  output wire cpu_stall;
  output reg [23:0] arr_addr;
  output reg arr_rd;
  input wire [23:0] arr_rdata;
  output reg arr_erase;
  output reg arr_wr;
  output wire [23:0] arr_wdata;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ERASE = 3'h1;
  localparam [2:0] ST_PROG = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  localparam [1:0] KEY_NONE = 2'h0;
  localparam [1:0] KEY_HALF = 2'h1;
  localparam [1:0] KEY_ARMED = 2'h2;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] key_r;
  reg [1:0] key_nxt;
  reg wr_r;
  reg write_enable_bit_r;
  reg err_r;
  reg erase_r;
  reg [3:0] op_r;
  reg [15:0] adr_lo_r;
  reg [7:0] adr_up_r;
  reg [7:0] page_r;
  reg [4:0] idx_r;
  reg [4:0] idx_nxt;
  reg rd_pend_r;
  reg rd_high_r;
  reg rd_byte_r;
  reg rd_odd_r;
  reg start_ok;
  reg start_bad;
  reg tmr_start;
  reg [2:0] lat_be;
  reg [23:0] lat_data;
  wire tmr_done;
  wire busy;
  wire ctrl_wr;
  wire key_wr;
  wire tbl_go;
  wire lat_we;
  wire [23:0] tbl_full_addr;
  wire [23:0] lat_rd_data;

  assign busy = (state_r != ST_IDLE);
  // R15 stall while busy
  assign cpu_stall = busy;
  assign ctrl_wr = reg_wr && (reg_addr == `SFPC_OFS_CTRL);
  assign key_wr = reg_wr && (reg_addr == `SFPC_OFS_KEY);
  assign tbl_go = tbl_valid && !busy;
  // R04 page joins ea
  assign tbl_full_addr = {page_r, tbl_ea};
  // R09 latch write only
  assign lat_we = tbl_go && tbl_write;
  assign arr_wdata = lat_rd_data;

  // R02 R03 lane select
  always @* begin
    lat_be = 3'h0;
    lat_data = 24'h000000;
    if (tbl_high) begin
      lat_data = {tbl_wdata[7:0], 16'h0000};
      lat_be = (tbl_byte && tbl_ea[0]) ? 3'h0 : 3'h4;
    end else if (tbl_byte) begin
      lat_data = {8'h00, tbl_wdata[7:0], tbl_wdata[7:0]};
      lat_be = tbl_ea[0] ? 3'h2 : 3'h1;
    end else begin
      lat_data = {8'h00, tbl_wdata};
      lat_be = 3'h3;
    end
  end

  // R07 latch by word index
  sfpc_latch_mem u_latch (
    .clk(clk),
    .wr_en(lat_we),
    .wr_idx(tbl_ea[5:1]),
    .wr_be(lat_be),
    .wr_data(lat_data),
    .rd_idx(idx_r),
    .rd_data(lat_rd_data)
  );

  // R15 nominal op time
  sfpc_op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(tmr_start),
    .done(tmr_done)
  );

  // R19 R20 start check
  always @* begin
    start_ok = 1'b0;
    start_bad = 1'b0;
    if (ctrl_wr && reg_wdata[`SFPC_CTRL_WR] && !busy) begin
      // R17 row op select
      if ((key_r == KEY_ARMED) && write_enable_bit_r && (reg_wdata[3:0] == `SFPC_OP_ROW)) begin
        start_ok = 1'b1;
      end else begin
        start_bad = 1'b1;
      end
    end
  end

  // R13 key sequence
  always @* begin
    key_nxt = key_r;
    if (reg_wr) begin
      if (key_wr && (reg_wdata[7:0] == `SFPC_KEY_FIRST)) begin
        key_nxt = KEY_HALF;
      end else if (key_wr && (key_r == KEY_HALF) &&
                   (reg_wdata[7:0] == `SFPC_KEY_SECOND)) begin
        key_nxt = KEY_ARMED;
      end else begin
        key_nxt = KEY_NONE;
      end
    end
  end

  always @* begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    tmr_start = 1'b0;
    case (state_r)
      ST_IDLE: begin
        idx_nxt = 5'h00;
        if (start_ok) begin
          state_nxt = reg_wdata[`SFPC_CTRL_ERASE] ? ST_ERASE : ST_PROG;
        end
      end
      ST_ERASE: begin
        tmr_start = 1'b1;
        state_nxt = ST_WAIT;
      end
      // R10 one row per cycle
      ST_PROG: begin
        idx_nxt = idx_r + 5'h01;
        if (idx_r == 5'h1f) begin
          tmr_start = 1'b1;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tmr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      key_r <= KEY_NONE;
      idx_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      key_r <= key_nxt;
      idx_r <= idx_nxt;
    end
  end

  // control register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= 1'b0;
      write_enable_bit_r <= 1'b0;
      err_r <= 1'b0;
      erase_r <= 1'b0;
      op_r <= 4'h0;
    end else begin
      if (ctrl_wr && !busy) begin
        write_enable_bit_r <= reg_wdata[`SFPC_CTRL_WRITE_ENABLE_BIT];
        erase_r <= reg_wdata[`SFPC_CTRL_ERASE];
        op_r <= reg_wdata[`SFPC_CTRL_OP_HI:`SFPC_CTRL_OP_LO];
        err_r <= reg_wdata[`SFPC_CTRL_ERR] | start_bad;
      end
      // R16 self clearing start
      if (start_ok) begin
        wr_r <= 1'b1;
      end else if ((state_r == ST_WAIT) && tmr_done) begin
        wr_r <= 1'b0;
      end
    end
  end

  // address and page registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adr_lo_r <= `SFPC_ADR_RESET;
      adr_up_r <= 8'h00;
      page_r <= 8'h00;
    end else begin
      if (tbl_go) begin
        // R11 capture low ea
        adr_lo_r <= tbl_full_addr[15:0];
        // R12 capture upper ea
        adr_up_r <= tbl_full_addr[23:16];
      end else if (reg_wr && !busy) begin
        // R14 direct writes
        if (reg_addr == `SFPC_OFS_ADR_LO) begin
          adr_lo_r <= reg_wdata;
        end
        if (reg_addr == `SFPC_OFS_ADR_UP) begin
          adr_up_r <= reg_wdata[7:0];
        end
      end
      if (reg_wr && (reg_addr == `SFPC_OFS_PAGE)) begin
        page_r <= reg_wdata[7:0];
      end
    end
  end

  // array strobes and address
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_addr <= 24'h000000;
      arr_rd <= 1'b0;
      arr_erase <= 1'b0;
      arr_wr <= 1'b0;
    end else begin
      arr_rd <= 1'b0;
      arr_erase <= 1'b0;
      // strobe in step with the latch word read at the same edge
      arr_wr <= (state_r == ST_PROG);
      if (tbl_go && !tbl_write) begin
        arr_rd <= 1'b1;
        arr_addr <= tbl_full_addr;
      end else if (state_r == ST_ERASE) begin
        // R01 whole row erase
        arr_erase <= 1'b1;
        arr_addr <= {adr_up_r, adr_lo_r[15:6], 6'h00};
      end else if (state_r == ST_PROG) begin
        // R05 row within panel
        arr_addr <= {adr_up_r, adr_lo_r[15:6], idx_r, 1'b0};
      end
    end
  end

  // table read return
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_r <= 1'b0;
      rd_high_r <= 1'b0;
      rd_byte_r <= 1'b0;
      rd_odd_r <= 1'b0;
      tbl_rdata <= 16'h0000;
      tbl_rvalid <= 1'b0;
    end else begin
      rd_pend_r <= arr_rd;
      if (tbl_go && !tbl_write) begin
        rd_high_r <= tbl_high;
        rd_byte_r <= tbl_byte;
        rd_odd_r <= tbl_ea[0];
      end
      tbl_rvalid <= rd_pend_r;
      if (rd_pend_r) begin
        if (rd_high_r) begin
          // R03 high byte
          tbl_rdata <= (rd_byte_r && rd_odd_r) ? 16'h0000 : {8'h00, arr_rdata[23:16]};
        end else if (rd_byte_r) begin
          // R02 low byte
          tbl_rdata <= {8'h00, rd_odd_r ? arr_rdata[15:8] : arr_rdata[7:0]};
        end else begin
          tbl_rdata <= arr_rdata[15:0];
        end
      end
    end
  end

  // register read port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SFPC_OFS_CTRL: begin
          reg_rdata <= {wr_r, write_enable_bit_r, err_r, 6'h00, erase_r, 2'h0, op_r};
        end
        `SFPC_OFS_ADR_LO: begin
          reg_rdata <= adr_lo_r;
        end
        `SFPC_OFS_ADR_UP: begin
          reg_rdata <= {8'h00, adr_up_r};
        end
        `SFPC_OFS_PAGE: begin
          reg_rdata <= {8'h00, page_r};
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

// ### sfpc_properties.sv
`timescale 1ns/1ps
module sfpc_properties #(
  parameter [16:0] OP_CYCLES = 17'd80000
) (
  input wire clk,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire tbl_valid,
  input wire tbl_write,
  input wire [15:0] tbl_ea,
  input wire tbl_rvalid,
  input wire cpu_stall,
  input wire [23:0] arr_addr,
  input wire arr_rd,
  input wire arr_erase
);
  reg [1:0] key_r;
  reg write_enable_bit_r;
  reg [15:0] adr_lo_m;
  // key progress, write enable and low address as software last set them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_r <= 2'd0;
      write_enable_bit_r <= 1'b0;
      adr_lo_m <= 16'h0000;
    end else begin
      if (reg_wr) begin
        key_r <= (reg_addr != 3'h3) ? 2'd0 : (reg_wdata[7:0] == 8'h55) ? 2'd1 :
          (reg_wdata[7:0] == 8'haa && key_r == 2'd1) ? 2'd2 : 2'd0;
        if (reg_addr == 3'h0 && !cpu_stall) write_enable_bit_r <= reg_wdata[14];
      end
      if (tbl_valid && !cpu_stall) adr_lo_m <= tbl_ea;
      else if (reg_wr && reg_addr == 3'h1 && !cpu_stall) adr_lo_m <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_key_reads_zero:
    assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata == 16'h0000) else $error("key read");
  a_read_fetch_addr:
    assert property (tbl_valid && !tbl_write && !cpu_stall |=>
      arr_rd && arr_addr[15:0] == $past(tbl_ea)) else $error("read fetch");
  a_read_answer_time:
    assert property (tbl_valid && !tbl_write && !cpu_stall |-> ##3 tbl_rvalid)
      else $error("read answer");
  a_write_no_stall:
    assert property (tbl_valid && tbl_write && !cpu_stall |=> !cpu_stall)
      else $error("latch write stalled");
  a_erase_whole_row:
    assert property (arr_erase |-> cpu_stall && arr_addr[15:0] == {adr_lo_m[15:6], 6'h00})
      else $error("erase not row aligned");
  a_stall_held:
    assert property ($rose(cpu_stall) |-> cpu_stall [*8]) else $error("stall dropped");
  a_start_needs_key:
    assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[15] && key_r != 2'd2 && !cpu_stall
      |=> !cpu_stall) else $error("start without key");
  a_start_needs_write_enable_bit:
    assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[15] && !write_enable_bit_r && !cpu_stall
      |=> !cpu_stall) else $error("start without enable");
endmodule
bind sfpc_top sfpc_properties #(.OP_CYCLES(OP_CYCLES)) u_props (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tbl_valid(tbl_valid), .tbl_write(tbl_write), .tbl_ea(tbl_ea),
  .tbl_rvalid(tbl_rvalid), .cpu_stall(cpu_stall), .arr_addr(arr_addr), .arr_rd(arr_rd),
  .arr_erase(arr_erase));

// ### sfpc_array_model.sv
`timescale 1ns/1ps
module sfpc_array_model (
  input wire clk,
  input wire [23:0] arr_addr,
  input wire arr_rd,
  output logic [23:0] arr_rdata,
  input wire arr_erase,
  input wire arr_wr,
  input wire [23:0] arr_wdata
);
  logic [23:0] mem [int];
  int wr_count = 0;
  // the array holds whole words; the byte select bit does not pick a word
  wire [23:0] word_addr = {arr_addr[23:1], 1'b0};
  initial arr_rdata = 24'h000000;
  always @(posedge clk) begin
    // whole row of 32 words cleared
    if (arr_erase) for (int j = 0; j < 32; j++) mem[int'(word_addr) + 2 * j] = 24'hffffff;
    if (arr_wr) begin
      mem[int'(word_addr)] = arr_wdata;
      wr_count++;
    end
    // answer only the cycle after a read, otherwise keep the line moving
    if (arr_rd) arr_rdata <= mem.exists(int'(word_addr)) ? mem[int'(word_addr)] : word_addr ^ 24'h5a5a5a;
    else arr_rdata <= ~arr_rdata;
  end
endmodule

// ### self_program_flash_controller_tb.sv
`timescale 1ns/1ps
module self_program_flash_controller_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tbl_valid = 1'b0;
  logic tbl_write = 1'b0;
  logic tbl_high = 1'b0;
  logic tbl_byte = 1'b0;
  logic [15:0] tbl_ea = 16'h0000;
  logic [15:0] tbl_wdata = 16'h0000;
  wire [15:0] reg_rdata;
  wire [15:0] tbl_rdata;
  wire tbl_rvalid, cpu_stall, arr_rd, arr_erase, arr_wr;
  wire [23:0] arr_addr, arr_rdata, arr_wdata;
  int bad_count = 0;
  int checks_done = 0;
  logic [15:0] d;
  // register, written value, value read back
  logic [34:0] rows [0:4] = '{
    {3'h1, 16'h1234, 16'h1234},
    {3'h2, 16'h12ab, 16'h00ab},
    {3'h0, 16'h0041, 16'h0041},
    {3'h3, 16'h0055, 16'h0000},
    {3'h5, 16'hffff, 16'h0000}};
  always #12.5 clk = ~clk;
  sfpc_top #(.OP_CYCLES(17'd20)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tbl_valid(tbl_valid), .tbl_write(tbl_write), .tbl_high(tbl_high), .tbl_byte(tbl_byte),
    .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
    .cpu_stall(cpu_stall), .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_rdata(arr_rdata),
    .arr_erase(arr_erase), .arr_wr(arr_wr), .arr_wdata(arr_wdata));
  sfpc_array_model mdl (.clk(clk), .arr_addr(arr_addr), .arr_rd(arr_rd),
    .arr_rdata(arr_rdata), .arr_erase(arr_erase), .arr_wr(arr_wr), .arr_wdata(arr_wdata));
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // kind is write, high, byte
  task automatic tbl(input logic [2:0] k, input logic [15:0] ea, input logic [15:0] wd,
      output logic [15:0] v);
    @(posedge clk);
    {tbl_write, tbl_high, tbl_byte} <= k;
    tbl_ea <= ea;
    tbl_wdata <= wd;
    tbl_valid <= 1'b1;
    @(posedge clk);
    tbl_valid <= 1'b0;
    v = 16'h0000;
    if (!k[2]) begin
      repeat (2) @(posedge clk);
      #1 check("tbl_rvalid", 24'h1, {23'h0, tbl_rvalid});
      v = tbl_rdata;
    end
  endtask
  task automatic go(input logic [15:0] c, input logic s);
    wr(3'h3, 16'h0055);
    wr(3'h3, 16'h00aa);
    wr(3'h0, c);
    #1 check("cpu_stall", {23'h0, s}, {23'h0, cpu_stall});
    for (int n = 0; n < 300 && cpu_stall; n++) @(posedge clk);
    check("stall end", 24'h0, {23'h0, cpu_stall});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][34:32], rows[i][31:16]);
      rd(rows[i][34:32], d);
      check("reg", {8'h0, rows[i][15:0]}, {8'h0, d});
    end
    wr(3'h4, 16'h0000);
    // latches filled in ascending order from an aligned row
    for (int i = 0; i < 32; i++) begin
      tbl(3'b100, 16'(2 * i), 16'ha5c0 + 16'(i), d);
      tbl(3'b110, 16'(2 * i), 16'h0030 + 16'(i), d);
    end
    wr(3'h1, 16'h0000);
    wr(3'h2, 16'h0000);
    wr(3'h0, 16'h4001);
    go(16'hc001, 1'b1);
    check("words programmed", 24'd32, mdl.wr_count[23:0]);
    rd(3'h0, d);
    check("start bit", 24'h004001, {8'h0, d});
    for (int i = 0; i < 32; i++) begin
      tbl(3'b000, 16'(2 * i), 16'h0000, d);
      check("low word", {8'h0, 16'ha5c0 + 16'(i)}, {8'h0, d});
      tbl(3'b010, 16'(2 * i), 16'h0000, d);
      check("high part", {8'h0, 16'h0030 + 16'(i)}, {8'h0, d});
    end
    tbl(3'b001, 16'h0002, 16'h0000, d);
    check("low byte", 24'h0000c1, {8'h0, d});
    tbl(3'b001, 16'h0003, 16'h0000, d);
    check("odd low byte", 24'h0000a5, {8'h0, d});
    tbl(3'b011, 16'h0003, 16'h0000, d);
    check("odd high byte", 24'h000000, {8'h0, d});
    wr(3'h4, 16'h0012);
    tbl(3'b000, 16'h1234, 16'h0000, d);
    check("paged read", {8'h0, 16'h1234 ^ 16'h5a5a}, {8'h0, d});
    rd(3'h1, d);
    check("addr low", 24'h001234, {8'h0, d});
    rd(3'h2, d);
    check("addr upper", 24'h000012, {8'h0, d});
    wr(3'h4, 16'h0000);
    wr(3'h1, 16'h0000);
    wr(3'h2, 16'h0000);
    wr(3'h0, 16'h4041);
    go(16'hc041, 1'b1);
    tbl(3'b000, 16'h0000, 16'h0000, d);
    check("erased first", 24'h00ffff, {8'h0, d});
    tbl(3'b010, 16'h003e, 16'h0000, d);
    check("erased last", 24'h0000ff, {8'h0, d});
    wr(3'h3, 16'h0055);
    wr(3'h1, 16'h0000);
    wr(3'h3, 16'h00aa);
    wr(3'h0, 16'hc041);
    #1 check("broken key", 24'h0, {23'h0, cpu_stall});
    rd(3'h0, d);
    check("refused flag", 24'h006041, {8'h0, d});
    wr(3'h0, 16'h0041);
    go(16'h8041, 1'b0);
    rd(3'h0, d);
    check("refused flag", 24'h002041, {8'h0, d});
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(3'h0, d);
    check("ctrl reset", 24'h0, {8'h0, d});
    end_of_test();
  end
endmodule
